// ---- sjpc_pkg.sv ----
package sjpc_pkg;

  // ****************************************************************
  // TAP states and sizes
  // ****************************************************************
  typedef enum logic [3:0]
  {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } sjpc_tap_e;

  // Test clock edges with select high that force the reset state
  localparam int unsigned SJPC_RESET_TCK_CNT = 5;
  // Synchroniser depth for pins arriving from outside
  localparam int unsigned SJPC_SYNC_STAGES   = 2;
  // Idle levels of the pins, loaded into their synchronisers at reset
  localparam logic        SJPC_TCK_IDLE      = 1'b0;
  localparam logic        SJPC_TMS_IDLE      = 1'b1;
  localparam logic        SJPC_TDI_IDLE      = 1'b1;
  localparam logic        SJPC_TRST_IDLE     = 1'b1;

endpackage

// ---- sjpc_sync.sv ----
`timescale 1ns/10ps
module sjpc_sync
#(
  parameter logic P_IDLE = 1'b0
)
(
  input  wire logic i_ref_clk,
  input  wire logic i_arst_n,
  input  wire logic i_async,
  output logic      o_sync
);
  import sjpc_pkg::*;

  logic [SJPC_SYNC_STAGES-1:0] stage_reg;

  // Two-flop synchroniser; only the next stage reads the first flop
  // Reset loads the pin's idle level, so no false edge or level follows reset
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      stage_reg <= {SJPC_SYNC_STAGES{P_IDLE}};
    else
      stage_reg <= {stage_reg[SJPC_SYNC_STAGES-2:0], i_async};
  end

  assign o_sync = stage_reg[SJPC_SYNC_STAGES-1];
endmodule

// ---- sjpc_ctrl.sv ----
`timescale 1ns/10ps
// Functional notes
// R1 - Flexible mode: select low claims shared pins
// R2 - Pins stay in test until reset state
// R3 - Reset state releases pins to user
// R4 - Five clocks with select high reach reset
// R5 - Dedicated mode: standard select, no sharing
// R6 - Checksum run drives data-out pin
// R7 - Low test reset initialises scan asynchronously; here done synchronously on the sampled pin, on the third ref rise
// R8 - Undriven test reset reads as deasserted
// R9 - Unreserved test reset pin is user I/O
// R10 - Test clock shared like data pins
// R11 - Standard state walk on clock rises
module sjpc_ctrl
(
  input  wire logic           i_ref_clk,
  input  wire logic           i_arst_n,
  input  wire logic           i_dedicated_mode,
  input  wire logic           i_trst_reserved,
  input  wire logic           i_checksum_busy,
  input  wire logic           i_tck,
  input  wire logic           i_tms,
  input  wire logic           i_tdi,
  input  wire logic           i_trst_n,
  input  wire logic           i_scan_tdo,
  input  wire logic           i_user_tdo,
  input  wire logic           i_user_tdo_oe,
  output logic                o_test_owns_pins,
  output logic                o_tck_rise,
  output logic                o_tck_fall,
  output logic                o_tdi,
  output logic                o_tdo,
  output logic                o_tdo_oe,
  output logic                o_user_tck_en,
  output logic                o_user_tdi_en,
  output logic                o_user_trst_en,
  output logic                o_scan_reset,
  output sjpc_pkg::sjpc_tap_e o_tap_state
);
  import sjpc_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_s;
  logic tck_d_reg;
  logic test_reg;
  logic test_next;
  logic tdo_reg;
  logic tdo_oe_reg;
  logic tdi_reg;
  logic sum_d_reg;
  sjpc_tap_e tap_reg;
  sjpc_tap_e tap_next;

  // Test clock idles low, so the edge detector sees no false rise after reset
  sjpc_sync
  #(
    .P_IDLE (SJPC_TCK_IDLE)
  )
  u_sync_tck
  (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_async   (i_tck),
    .o_sync    (tck_s)
  );

  // Select idles high; a low here would claim the pins right after reset
  sjpc_sync
  #(
    .P_IDLE (SJPC_TMS_IDLE)
  )
  u_sync_tms
  (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_async   (i_tms),
    .o_sync    (tms_s)
  );

  // Data in idles high
  sjpc_sync
  #(
    .P_IDLE (SJPC_TDI_IDLE)
  )
  u_sync_tdi
  (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_async   (i_tdi),
    .o_sync    (tdi_s)
  );

  // Test reset idles high behind its pull-up, so reset leaves the scan alone
  sjpc_sync
  #(
    .P_IDLE (SJPC_TRST_IDLE)  // R8
  )
  u_sync_trst
  (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_async   (i_trst_n),
    .o_sync    (trst_s)
  );

  // ****************************************************************
  // Edge detection and scan reset
  // ****************************************************************
  wire tck_rise  = tck_s & ~tck_d_reg;
  wire tck_fall  = ~tck_s & tck_d_reg;
  // Pull-up makes a floating pin read high, so only a driven low resets
  wire trst_hit  = i_trst_reserved & ~trst_s;  // R7 R8 R9
  // Dedicated mode keeps the port always live; flexible mode only when owned or while select is low
  wire port_live = i_dedicated_mode | test_reg | ~tms_s;  // R5 R1 R10
  wire tck_step  = tck_rise & port_live;

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      tck_d_reg <= SJPC_TCK_IDLE;
    else
      tck_d_reg <= tck_s;
  end

  // ****************************************************************
  // TAP state machine
  // ****************************************************************
  // Five rises with select high from any state land in reset
  always_comb
  begin
    tap_next = tap_reg;
    unique case (tap_reg)  // R11 R4
      TAP_RESET:    tap_next = tms_s ? TAP_RESET   : TAP_IDLE;
      TAP_IDLE:     tap_next = tms_s ? TAP_SEL_DR  : TAP_IDLE;
      TAP_SEL_DR:   tap_next = tms_s ? TAP_SEL_IR  : TAP_CAP_DR;
      TAP_CAP_DR:   tap_next = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = tms_s ? TAP_UPD_DR  : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = tms_s ? TAP_UPD_DR  : TAP_SHIFT_DR;
      TAP_UPD_DR:   tap_next = tms_s ? TAP_SEL_DR  : TAP_IDLE;
      TAP_SEL_IR:   tap_next = tms_s ? TAP_RESET   : TAP_CAP_IR;
      TAP_CAP_IR:   tap_next = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = tms_s ? TAP_UPD_IR  : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = tms_s ? TAP_UPD_IR  : TAP_SHIFT_IR;
      TAP_UPD_IR:   tap_next = tms_s ? TAP_SEL_DR  : TAP_IDLE;
    endcase
  end

  // Test reset acts synchronously on the sampled pin, on the third ref rise after the pin falls, without a test clock
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      tap_reg <= TAP_RESET;
    else if (trst_hit)
      tap_reg <= TAP_RESET;  // R7
    else if (tck_step)
      tap_reg <= tap_next;  // R11
  end

  // ****************************************************************
  // Pin ownership
  // ****************************************************************
  // Claim on select low; hold regardless of select until reset state
  always_comb
  begin
    test_next = test_reg;
    if (i_dedicated_mode)
      test_next = 1'b1;  // R5
    else if (trst_hit)
      test_next = 1'b0;  // R3
    else if (tck_step && tap_next == TAP_RESET)
      test_next = 1'b0;  // R3 R4
    else if (tap_reg == TAP_RESET && tms_s)
      test_next = 1'b0;  // R3
    else if (!tms_s)
      test_next = 1'b1;  // R1 R2 R10
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      test_reg <= 1'b0;
    else
      test_reg <= test_next;
  end

  // ****************************************************************
  // Data pins; scan data-out updated on test clock falls
  // ****************************************************************
  wire shifting   = (tap_reg == TAP_SHIFT_DR) | (tap_reg == TAP_SHIFT_IR);
  wire tdo_oe_nxt = (test_reg & shifting) | i_checksum_busy | (~test_reg & i_user_tdo_oe);  // R6
  wire tdo_nxt    = (test_reg | i_checksum_busy) ? i_scan_tdo : i_user_tdo;  // R6 R3

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
      tdi_reg    <= 1'b0;
      sum_d_reg  <= 1'b0;
    end
    else
    begin
      tdi_reg   <= tdi_s;
      sum_d_reg <= i_checksum_busy;
      // Checksum and user paths update every cycle; scan path on falls only.
      // The cycle after a checksum also updates, so a stopped test clock cannot leave the pin driven
      if (tck_fall || !test_reg || i_checksum_busy || sum_d_reg)  // R6
      begin
        tdo_reg    <= tdo_nxt;
        tdo_oe_reg <= tdo_oe_nxt;
      end
    end
  end

  assign o_test_owns_pins = test_reg;
  assign o_tck_rise       = tck_step;
  assign o_tck_fall       = tck_fall & test_reg;
  assign o_tdi            = tdi_reg;
  assign o_tdo            = tdo_reg;
  assign o_tdo_oe         = tdo_oe_reg;
  assign o_user_tck_en    = ~test_reg;  // R10 R3
  assign o_user_tdi_en    = ~test_reg;  // R3
  assign o_user_trst_en   = ~i_trst_reserved;  // R9
  assign o_scan_reset     = (tap_reg == TAP_RESET);
  assign o_tap_state      = tap_reg;
endmodule

// ---- sjpc_chk.sv ----
`timescale 1ns/10ps
// ***
// Pin ownership, data-out drive and scan reset checks
// ***
module sjpc_chk
(
  input wire logic i_ref_clk, i_arst_n, i_dedicated_mode, i_trst_reserved, i_checksum_busy, i_tms, i_trst_n,
  input wire logic o_test_owns_pins, o_tdo_oe, o_user_tck_en, o_user_trst_en,
  input wire sjpc_pkg::sjpc_tap_e o_tap_state
);
  import sjpc_pkg::*;
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  // Select low only counts with test reset idle, since reset wins
  wire lo = !i_dedicated_mode && !i_tms && i_trst_n;
  wire hi = !i_dedicated_mode && i_tms;
  wire rs = o_tap_state == TAP_RESET;
  wire tr = i_trst_reserved && !i_trst_n;
  a_claim_pins: assert property (lo [*6] |=> o_test_owns_pins) else $error("no claim");
  a_hold_pins: assert property (o_test_owns_pins && !rs && !tr |=> o_test_owns_pins || rs) else $error("early drop");
  a_release_pins: assert property (hi [*5] ##0 rs |=> !o_test_owns_pins) else $error("no release");
  a_clk_user: assert property (o_user_tck_en == !o_test_owns_pins) else $error("clock pin owner");
  a_dedic_owned: assert property (i_dedicated_mode [*3] |-> o_test_owns_pins) else $error("not owned");
  a_sum_drive: assert property (i_checksum_busy [*2] |-> o_tdo_oe) else $error("no drive");
  a_trst_reset: assert property (tr [*4] |-> rs) else $error("no scan reset");
  a_trst_user: assert property (o_user_trst_en == !i_trst_reserved) else $error("reset pin owner");
  c_shift: cover property (o_tap_state == TAP_SHIFT_DR);
  c_drop: cover property ($fell(o_test_owns_pins));
  c_trst: cover property (tr [*4]);
endmodule
bind sjpc_ctrl sjpc_chk u_chk (.i_ref_clk, .i_arst_n, .i_dedicated_mode, .i_trst_reserved, .i_checksum_busy,
  .i_tms, .i_trst_n, .o_test_owns_pins, .o_tdo_oe, .o_user_tck_en, .o_user_trst_en, .o_tap_state);

// ---- sjpc_tester.sv ----
`timescale 1ns/10ps
// ***
// Tester on the shared test pins
// ***
module sjpc_tester
(
  input  wire logic i_ref_clk,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi
);
  // Clock stands low between frames
  initial {o_tck, o_tms, o_tdi} = 3'b011;
  // One bit per clock; select and data change on a ref rise while clock is low
  task automatic step(input logic tms, input logic tdi);
    @(posedge i_ref_clk);
    o_tms <= tms;
    o_tdi <= tdi;
    #62.5;
    o_tck <= 1'b1;
    #62.5;
    o_tck <= 1'b0;
    // Return at a settled point, clear of the edge that the fall shares
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  // Five clocks with select high bring the port home
  task automatic leave();
    repeat (5) step(1'b1, 1'b0);
    o_tdi <= 1'b1;
  endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
// ***
// Bench for shared test pin control
// ***
module tb_top;
  import sjpc_pkg::*;
  logic      i_ref_clk = 1'b0;
  logic      arst_n = 1'b0;
  logic      ded = 1'b0;
  logic      rsv = 1'b1;
  logic      sum = 1'b0;
  logic      trst_n = 1'b1;
  logic      sdo = 1'b0;
  logic      udo = 1'b0;
  logic      uoe = 1'b0;
  logic      tck, tms, tdi, own, oe, tdo, utck, utdi, utrst;
  logic      rise, fall, otdi, srst;
  sjpc_tap_e st;
  int        n_fail = 0;
  int        comparisons = 0;
  int        n_rise = 0;
  int        n_fall = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  sjpc_tester tester (.i_ref_clk(i_ref_clk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  sjpc_ctrl DUT (.i_ref_clk(i_ref_clk), .i_arst_n(arst_n), .i_dedicated_mode(ded), .i_trst_reserved(rsv),
    .i_checksum_busy(sum), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n), .i_scan_tdo(sdo),
    .i_user_tdo(udo), .i_user_tdo_oe(uoe), .o_test_owns_pins(own), .o_tck_rise(rise), .o_tck_fall(fall),
    .o_tdi(otdi), .o_tdo(tdo), .o_tdo_oe(oe), .o_user_tck_en(utck), .o_user_tdi_en(utdi),
    .o_user_trst_en(utrst), .o_scan_reset(srst), .o_tap_state(st));
  // Count the test clock pulses that the port accepts
  always @(posedge i_ref_clk)
  begin
    if (rise === 1'b1)
      n_rise <= n_rise + 1;
    if (fall === 1'b1)
      n_fall <= n_fall + 1;
  end
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Claim, walk to shift, then five high selects
  task automatic t_walk();
    tester.step(1'b0, 1'b1);
    chk("own", own, 1'b1);
    chk("utck", utck, 1'b0);
    chk("tdi", otdi, 1'b1);
    tester.step(1'b1, 1'b0);
    tester.step(1'b0, 1'b1);
    tester.step(1'b0, 1'b0);
    chk("shift", st, TAP_SHIFT_DR);
    // Drive follows the test clock fall, two sync stages late
    wt(3);
    @(negedge i_ref_clk);
    chk("oe", oe, 1'b1);
    repeat (4) tester.step(1'b1, 1'b0);
    chk("held", own, 1'b1);
    chk("sel_ir", st, TAP_SEL_IR);
    tester.step(1'b1, 1'b0);
    chk("utdi", utdi, 1'b1);
    chk("rises", 4'(n_rise), 4'h9);
    chk("falls", 4'(n_fall), 4'h8);
    $display("walk done");
  endtask
  // Reserved reset acts, unreserved is ignored
  task automatic t_trst();
    tester.step(1'b0, 1'b0);
    wt(1);
    trst_n <= 1'b0;
    wt(6);
    @(negedge i_ref_clk);
    chk("trst", st, TAP_RESET);
    chk("scan rst", srst, 1'b1);
    wt(1);
    trst_n <= 1'b1;
    rsv <= 1'b0;
    tester.step(1'b0, 1'b0);
    wt(1);
    trst_n <= 1'b0;
    wt(6);
    @(negedge i_ref_clk);
    chk("ignored", st, TAP_IDLE);
    chk("utrst", utrst, 1'b1);
    wt(1);
    trst_n <= 1'b1;
    // Let the pin settle through its synchroniser before reserving it again
    wt(3);
    rsv <= 1'b1;
    tester.leave();
    $display("trst done");
  endtask
  // Checksum drives data-out while idle
  task automatic t_sum();
    int r0;
    // Select high with pins released: the test clock is refused
    r0 = n_rise;
    tester.step(1'b1, 1'b0);
    chk("refused", 4'(n_rise - r0), 4'h0);
    chk("refused own", own, 1'b0);
    wt(1);
    sdo <= 1'b1;
    sum <= 1'b1;
    wt(4);
    @(negedge i_ref_clk);
    chk("sum oe", oe, 1'b1);
    chk("sum tdo", tdo, 1'b1);
    wt(1);
    sum <= 1'b0;
    sdo <= 1'b0;
    wt(4);
    @(negedge i_ref_clk);
    chk("sum off", oe, 1'b0);
    // Released pin follows the user drive again
    wt(1);
    udo <= 1'b1;
    uoe <= 1'b1;
    wt(4);
    @(negedge i_ref_clk);
    chk("user oe", oe, 1'b1);
    chk("user tdo", tdo, 1'b1);
    wt(1);
    udo <= 1'b0;
    uoe <= 1'b0;
    $display("sum done");
  endtask
  // Dedicated mode keeps pins in test
  task automatic t_ded();
    wt(1);
    ded <= 1'b1;
    wt(4);
    @(negedge i_ref_clk);
    chk("ded", utck, 1'b0);
    tester.leave();
    chk("ded own", own, 1'b1);
    wt(1);
    ded <= 1'b0;
    // Back in flexible mode, in reset with select high: pins go to user
    wt(3);
    @(negedge i_ref_clk);
    chk("ded off", own, 1'b0);
    $display("ded done");
  endtask
  initial
  begin
    wt(10);
    arst_n <= 1'b1;
    wt(3);
    t_walk();
    t_trst();
    t_sum();
    t_ded();
    final_report();
  end
  // Whole run is near 4 us
  initial
  begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule
